//--- fbpc_core_model.sv
`timescale 1ns/100ps
`default_nettype none

// Core and debugger read port; address lines show the inverse of the last address between requests
module fbpc_core_model
  import fbpc_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              req_i,
  input  wire logic              fetch_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  output fbpc_rd_req_t           rd_req_o
);
  logic [ADDR_W-1:0] last;

  // Idle address shows the inverse of the last one so stale values never match
  always_ff @(posedge clk_sys_i) begin
    if (req_i) last <= addr_i;
  end
  assign rd_req_o = '{valid: req_i, fetch: fetch_i, addr: req_i ? addr_i : ~last};
endmodule

`default_nettype wire

//--- fbpc_ctrl.sv
// Notes on behaviour
// - Manage 64 KB array; decode whole range for read, program and erase.
// - Processor reads complete in one clock cycle, no wait states.
// - Array splits into 1 KB erase units, each erasable on its own.
// - Finished erase leaves every bit of the block at one.
// - Protection applies per 2 KB unit, each with its own attribute.
// - Each protection unit can be read-only or execute-only, besides unprotected.
// - Read-only unit refuses every erase and program request.
// - Execute-only unit refuses modify and serves instruction fetches only.
`timescale 1ns/100ps
`default_nettype none

module fbpc_ctrl
  import fbpc_pkg::*;
(
  input  wire logic          clk_sys_i,
  input  wire logic          rst_n_i,
  input  wire fbpc_rd_req_t  rd_req_i,
  output fbpc_rd_rsp_t       rd_rsp_o,
  input  wire fbpc_mod_req_t mod_req_i,
  output logic               mod_busy_o,
  output logic               mod_done_o,
  input  wire logic          prot_wr_i,
  input  wire logic [PROT_W-1:0] prot_unit_i,
  input  wire fbpc_prot_t    prot_attr_i,
  output logic               viol_o,
  input  wire logic          viol_clr_i
);

  typedef enum logic [0:0] {FBPC_IDLE, FBPC_ERASE} fbpc_state_t;

  logic [DATA_W-1:0] mem [WORDS];
  fbpc_prot_t        prot [PROT_UNITS];
  fbpc_prot_t        next_prot [PROT_UNITS];

  fbpc_state_t        state, next_state;
  logic [BLK_W-1:0]   blk, next_blk;
  logic [ERASE_W-1:0] ecnt, next_ecnt;
  fbpc_rd_rsp_t       next_rsp;
  logic               next_busy, next_done, next_viol;
  logic               rd_deny, mod_deny, mod_req, wr_en;
  logic [WADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0]  wr_data;
  fbpc_prot_t         rd_attr, mod_attr;

  // Attribute lookup by the 2 KB unit that the address falls in
  assign rd_attr  = prot[rd_req_i.addr[ADDR_W-1:PROT_LSB]];
  assign mod_attr = prot[mod_req_i.addr[ADDR_W-1:PROT_LSB]];
  assign rd_deny  = rd_req_i.valid && !rd_req_i.fetch && (rd_attr == FBPC_PROT_XO);
  assign mod_req  = (mod_req_i.cmd == FBPC_CMD_PROG) || (mod_req_i.cmd == FBPC_CMD_ERASE);
  assign mod_deny = mod_req && (mod_attr != FBPC_PROT_NONE);

  // Protection table, one independent attribute per unit
  generate
    for (genvar u = 0; u < PROT_UNITS; u++) begin : g_prot
      always_comb begin
        next_prot[u] = prot[u];
        if (prot_wr_i && (prot_unit_i == PROT_W'(u))) begin
          next_prot[u] = prot_attr_i;
        end
      end
      always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
          prot[u] <= FBPC_PROT_NONE;
        end else begin
          prot[u] <= next_prot[u];
        end
      end
    end
  endgenerate

  // Read answer one edge after request; denied reads return no content
  always_comb begin
    next_rsp.valid  = rd_req_i.valid;
    next_rsp.denied = rd_deny;
    next_rsp.data   = DENY_WORD;
    if (rd_req_i.valid && !rd_deny) begin
      next_rsp.data = mem[rd_req_i.addr[ADDR_W-1:2]];
    end
  end

  // Modify sequencer: erase walks 256 words, one per cycle; requests while busy are ignored
  always_comb begin
    next_state = state;
    next_blk   = blk;
    next_ecnt  = ecnt;
    next_done  = 1'b0;
    wr_en      = 1'b0;
    wr_addr    = mod_req_i.addr[ADDR_W-1:2];
    wr_data    = mod_req_i.data;
    case (state)
      FBPC_IDLE: begin
        if (mod_req && !mod_deny) begin
          if (mod_req_i.cmd == FBPC_CMD_PROG) begin
            wr_en     = 1'b1;   // Program takes one cycle
            next_done = 1'b1;
          end else begin
            next_blk   = mod_req_i.addr[ADDR_W-1:BLK_LSB];
            next_ecnt  = '0;
            next_state = FBPC_ERASE;
          end
        end
      end
      FBPC_ERASE: begin
        wr_en     = 1'b1;
        wr_addr   = {blk, ecnt};
        wr_data   = ERASED_WORD;
        next_ecnt = ecnt + 1'b1;
        if (ecnt == ERASE_LAST) begin
          next_state = FBPC_IDLE;
          next_done  = 1'b1;
        end
      end
      default: next_state = FBPC_IDLE;
    endcase
    next_busy = (next_state == FBPC_ERASE);
  end

  // Violation flag: a new violation wins over a clear in the same cycle
  always_comb begin
    next_viol = viol_o;
    if (viol_clr_i) begin
      next_viol = 1'b0;
    end
    if (rd_deny || (mod_deny && (state == FBPC_IDLE))) begin
      next_viol = 1'b1;
    end
  end

  // Array write port; no reset on storage, contents persist
  always_ff @(posedge clk_sys_i) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Control registers
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state      <= FBPC_IDLE;
      blk        <= '0;
      ecnt       <= '0;
      rd_rsp_o   <= '0;
      mod_busy_o <= 1'b0;
      mod_done_o <= 1'b0;
      viol_o     <= 1'b0;
    end else begin
      state      <= next_state;
      blk        <= next_blk;
      ecnt       <= next_ecnt;
      rd_rsp_o   <= next_rsp;
      mod_busy_o <= next_busy;
      mod_done_o <= next_done;
      viol_o     <= next_viol;
    end
  end

  // Checks
  a_read_one_cycle: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    rd_req_i.valid |=> rd_rsp_o.valid)
    else $error("read not answered next cycle");

  a_xo_data_denied: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    rd_deny |=> (rd_rsp_o.denied && rd_rsp_o.data == DENY_WORD && viol_o))
    else $error("execute-only data read leaked");

  a_fetch_served: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (rd_req_i.valid && rd_req_i.fetch) |=> !rd_rsp_o.denied)
    else $error("instruction fetch denied");

  a_ro_no_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (state == FBPC_IDLE && mod_deny) |-> !wr_en)
    else $error("protected unit modified");

  a_refuse_flags: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (state == FBPC_IDLE && mod_deny) |=> (viol_o && !mod_busy_o && !mod_done_o))
    else $error("refused modify not flagged");

  a_erase_len: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (state == FBPC_IDLE && next_state == FBPC_ERASE) |=> mod_busy_o ##[255:256] mod_done_o)
    else $error("erase length wrong");

  a_erase_ones: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (state == FBPC_ERASE) |-> (wr_en && wr_data == ERASED_WORD))
    else $error("erase writes non-ones");

  a_erase_in_blk: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (state == FBPC_ERASE) |-> (wr_addr[WADDR_W-1:ERASE_W] == blk))
    else $error("erase left its block");

  a_viol_sticky: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (viol_o && !viol_clr_i) |=> viol_o)
    else $error("violation flag dropped");

  c_erase_done: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    mod_busy_o ##1 mod_done_o);
  c_xo_deny: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) rd_rsp_o.denied);
  c_prog: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    mod_done_o && !mod_busy_o);
  c_ro_refuse: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    mod_deny && mod_attr == FBPC_PROT_RO);

endmodule

`default_nettype wire

//--- fbpc_pkg.sv
package fbpc_pkg;

  // Array geometry: 64 KB of 32-bit words
  localparam int unsigned FLASH_BYTES    = 65536;
  localparam int unsigned WORD_BYTES     = 4;
  localparam int unsigned WORDS          = FLASH_BYTES / WORD_BYTES;
  localparam int unsigned ADDR_W         = 16;
  localparam int unsigned WADDR_W        = 14;
  localparam int unsigned DATA_W         = 32;
  // Erase unit 1 KB, protection unit 2 KB
  localparam int unsigned ERASE_BYTES    = 1024;
  localparam int unsigned ERASE_WORDS    = ERASE_BYTES / WORD_BYTES;
  localparam int unsigned ERASE_W        = 8;
  localparam int unsigned BLK_LSB        = 10;
  localparam int unsigned BLK_W          = 6;
  localparam int unsigned PROT_LSB       = 11;
  localparam int unsigned PROT_W         = 5;
  localparam int unsigned PROT_UNITS     = 32;
  localparam logic [DATA_W-1:0] ERASED_WORD = 32'hFFFFFFFF;
  localparam logic [DATA_W-1:0] DENY_WORD   = 32'h00000000;

  // Protection attribute per 2 KB unit
  typedef enum logic [1:0] {
    FBPC_PROT_NONE = 2'h0,
    FBPC_PROT_RO   = 2'h1,
    FBPC_PROT_XO   = 2'h2
  } fbpc_prot_t;

  // Modify request: program one word or erase one 1 KB block
  typedef enum logic [1:0] {
    FBPC_CMD_IDLE  = 2'h0,
    FBPC_CMD_PROG  = 2'h1,
    FBPC_CMD_ERASE = 2'h2
  } fbpc_cmd_t;

  typedef struct packed {
    logic              valid;
    logic              fetch;   // High for instruction fetch, low for data/debug read
    logic [ADDR_W-1:0] addr;
  } fbpc_rd_req_t;

  typedef struct packed {
    fbpc_cmd_t         cmd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fbpc_mod_req_t;

  typedef struct packed {
    logic              valid;
    logic              denied;
    logic [DATA_W-1:0] data;
  } fbpc_rd_rsp_t;

  localparam logic [ERASE_W-1:0] ERASE_LAST = 8'hFF;

endpackage

//--- test_flash_block_protection_ctrl.sv
`timescale 1ns/100ps
`default_nettype none

module test_flash_block_protection_ctrl
  import fbpc_pkg::*;
;
  logic clk_sys_i = 0, rst_n_i = 0, req = 0, fe = 0, pwr = 0, vclr = 0;
  logic [ADDR_W-1:0] ad = 16'h0000;
  logic [PROT_W-1:0] pu = 5'h00;
  fbpc_prot_t pa = FBPC_PROT_NONE;
  fbpc_mod_req_t mreq = '0;
  fbpc_rd_req_t rq;
  fbpc_rd_rsp_t rs;
  logic busy, done, viol;
  logic [31:0] mem [int];
  int pr [32];
  int num_errors = 0, total_checks = 0, cyc = 0, seed = 46625, i, n;
  logic [15:0] aq [$];
  logic [15:0] a;
  logic [31:0] d;

  always #50 clk_sys_i = ~clk_sys_i;

  fbpc_core_model i_fbpc_core_model (.clk_sys_i(clk_sys_i), .req_i(req), .fetch_i(fe),
    .addr_i(ad), .rd_req_o(rq));
  fbpc_ctrl i_fbpc_ctrl (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .rd_req_i(rq),
    .rd_rsp_o(rs), .mod_req_i(mreq), .mod_busy_o(busy), .mod_done_o(done),
    .prot_wr_i(pwr), .prot_unit_i(pu), .prot_attr_i(pa), .viol_o(viol),
    .viol_clr_i(vclr));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // One edge then clear the sticky flag again
  task automatic step_clr(input logic c);
    vclr = c;
    @(posedge clk_sys_i);
    #10 vclr = 0;
  endtask

  // Read one word; expectation from the model's memory and attributes
  task automatic rd(input logic f, input logic [15:0] ar);
    logic dn;
    dn = !f && pr[ar[15:11]] == 2;
    req = 1;
    fe = f;
    ad = ar;
    @(posedge clk_sys_i);
    #10 req = 0;
    // Answer stands one cycle only, so look right after the answering edge
    chk("rvalid", rs.valid, 1);
    chk("denied", rs.denied, dn);
    chk("rdata", rs.data, dn ? DENY_WORD : mem[ar[15:2]]);
    chk("rviol", viol, dn);
    // Let an edge pass so the next request never reuses this time step
    if (dn) step_clr(1);
    else begin
      @(posedge clk_sys_i);
      #10;
    end
  endtask

  // Program or erase; a refused request must change nothing and flag
  task automatic md(input fbpc_cmd_t c, input logic [15:0] ar, input logic [31:0] d);
    logic ok;
    ok = pr[ar[15:11]] == 0;
    mreq = '{cmd: c, addr: ar, data: d};
    @(posedge clk_sys_i);
    #10 mreq.cmd = FBPC_CMD_IDLE;
    chk("done", done, ok && c == FBPC_CMD_PROG);
    chk("busy", busy, ok && c == FBPC_CMD_ERASE);
    chk("mviol", viol, !ok);
    if (!ok) step_clr(1);
    else if (c == FBPC_CMD_PROG) mem[ar[15:2]] = d;
    else begin
      n = 0;
      while (done !== 1'b1 && n < 300) begin
        @(posedge clk_sys_i);
        #10 n++;
      end
      chk("erase len", n, 256);
      for (int k = 0; k < 256; k++) mem[{ar[15:10], 8'(k)}] = ERASED_WORD;
    end
  endtask

  task automatic prot(input logic [4:0] u, input fbpc_prot_t t);
    pwr = 1;
    pu = u;
    pa = t;
    pr[u] = t;
    @(posedge clk_sys_i);
    #10 pwr = 0;
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Hang guard well past the longest sequence
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 4000) begin
      num_errors++;
      print_verdict();
    end
  end

  initial begin
    foreach (pr[k]) pr[k] = 0;
    repeat (3) @(posedge clk_sys_i);
    #10 rst_n_i = 1;
    // Random words, top of range included, programmed back to back
    for (i = 0; i < 5; i++) begin
      a = (i == 4) ? 16'hFFFC : 16'($random(seed)) & 16'hFFFC;
      d = $random(seed);
      aq.push_back(a);
      // Command held up between requests; each edge takes one program
      mreq = '{cmd: FBPC_CMD_PROG, addr: a, data: d};
      @(posedge clk_sys_i);
      #10 mem[a[15:2]] = d;
      chk("done", done, 1);
    end
    mreq.cmd = FBPC_CMD_IDLE;
    foreach (aq[k]) rd(0, aq[k]);
    md(FBPC_CMD_ERASE, aq[0], 0);
    foreach (aq[k]) rd(k[0], aq[k]);
    a = aq[1];
    prot(a[15:11], FBPC_PROT_RO);
    md(FBPC_CMD_PROG, a, 32'h5A5A5A5A);
    md(FBPC_CMD_ERASE, a, 0);
    rd(0, a);
    md(FBPC_CMD_PROG, a ^ 16'h0800, 32'h0F0F0F0F);
    rd(0, a ^ 16'h0800);
    prot(a[15:11], FBPC_PROT_XO);
    rd(1, a);
    rd(0, a);
    md(FBPC_CMD_ERASE, a ^ 16'h0400, 0);
    prot(a[15:11], FBPC_PROT_NONE);
    rd(0, a);
    md(FBPC_CMD_PROG, a, 32'hC3C3C3C3);
    rd(0, a);
    print_verdict();
  end
endmodule

`default_nettype wire
